// [rtl/converter_input_control.sv]
// register file, trigger logic and input routing around the converter core
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module converter_input_control (
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [2:0]  i_timer_overflow,
  input  wire logic        i_conversion_done,
  input  wire logic [7:0]  i_result_high,
  output logic             o_conversion_start,
  output logic [7:0]       o_positive_switch,
  output logic [7:0]       o_negative_switch,
  output logic             o_negative_half_supply,
  output logic             o_internal_reference,
  output logic             o_differential
);
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b01,
    CONV_BUSY = 2'b10
  } conv_state_t;

  logic [7:0]  control_r;
  logic [7:0]  control_nxt;
  logic [7:0]  result_r;
  logic [7:0]  result_nxt;
  logic        enable_r;
  logic        enable_nxt;
  conv_state_t state_r;
  conv_state_t state_nxt;
  logic        start_r;
  logic        start_nxt;
  logic [11:0] awaddr_r;
  logic [11:0] awaddr_nxt;
  logic        aw_held_r;
  logic        aw_held_nxt;
  logic [31:0] wdata_r;
  logic [31:0] wdata_nxt;
  logic        wstrb0_r;
  logic        wstrb0_nxt;
  logic        w_held_r;
  logic        w_held_nxt;
  logic        bvalid_r;
  logic        bvalid_nxt;
  logic [1:0]  bresp_r;
  logic [1:0]  bresp_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0]  rresp_r;
  logic [1:0]  rresp_nxt;
  logic [7:0]  pos_r;
  logic [7:0]  pos_nxt;
  logic [7:0]  neg_r;
  logic [7:0]  neg_nxt;
  logic        half_r;
  logic        half_nxt;
  logic [3:0]  ext_sync;
  logic [7:0]  result_sync;
  logic [2:0]  ovf_sync;
  logic        done_sync;
  logic        done_d_r;
  logic        wr_fire;
  logic        wr_ok;
  logic        hw_trigger;
  logic        sw_start;
  logic        done_edge;

  // timers and the core live outside this clock domain, so their levels pass through two-flop synchronisers
  pin_sync #(.WIDTH(4)) u_evt_sync (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_async ({i_conversion_done, i_timer_overflow}),
    .o_sync  (ext_sync)
  );
  pin_sync #(.WIDTH(8)) u_res_sync (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_async (i_result_high),
    .o_sync  (result_sync)
  );
  assign ovf_sync  = ext_sync[2:0];
  assign done_sync = ext_sync[3];

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  assign wr_fire   = aw_held_r && w_held_r && !bvalid_r;
  assign wr_ok     = wr_fire && wstrb0_r;
  assign done_edge = done_sync && !done_d_r;
  // a start counts the enable written with it, since the same write replaces enable
  assign sw_start  = wr_ok && awaddr_r == converter_input_control_pkg::START_CONTROL_ADDR
                     && wdata_r[converter_input_control_pkg::START_BIT]
                     && wdata_r[converter_input_control_pkg::ENABLE_BIT];

  always_comb begin
    hw_trigger = 1'b0;
    unique case (control_r[converter_input_control_pkg::TRIG_HI:
                           converter_input_control_pkg::TRIG_LO])
      converter_input_control_pkg::TRIG_SOFTWARE: hw_trigger = 1'b0;
      converter_input_control_pkg::TRIG_TIMER0:   hw_trigger = ovf_sync[0];
      converter_input_control_pkg::TRIG_TIMER1:   hw_trigger = ovf_sync[1];
      converter_input_control_pkg::TRIG_TIMER2:   hw_trigger = ovf_sync[2];
    endcase
  end

  always_comb begin
    awaddr_nxt = awaddr_r;
    aw_held_nxt = aw_held_r;
    wdata_nxt  = wdata_r;
    wstrb0_nxt = wstrb0_r;
    w_held_nxt = w_held_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    control_nxt = control_r;
    enable_nxt = enable_r;
    if (s_axi_awvalid && s_axi_awready) begin
      awaddr_nxt  = s_axi_awaddr;
      aw_held_nxt = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wdata_nxt  = s_axi_wdata;
      wstrb0_nxt = s_axi_wstrb[0];
      w_held_nxt = 1'b1;
    end
    if (wr_fire) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = converter_input_control_pkg::RESP_OKAY;
      unique case (awaddr_r)
        converter_input_control_pkg::INPUT_CONTROL_ADDR: begin
          if (wstrb0_r) begin
            control_nxt = wdata_r[7:0];
          end
        end
        converter_input_control_pkg::START_CONTROL_ADDR: begin
          if (wstrb0_r) begin
            enable_nxt = wdata_r[converter_input_control_pkg::ENABLE_BIT];
          end
        end
        converter_input_control_pkg::RESULT_HIGH_ADDR: ;
        default: bresp_nxt = converter_input_control_pkg::RESP_SLVERR;
      endcase
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = converter_input_control_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        converter_input_control_pkg::RESULT_HIGH_ADDR:   rdata_nxt = {24'h000000, result_r};
        converter_input_control_pkg::INPUT_CONTROL_ADDR: rdata_nxt = {24'h000000, control_r};
        converter_input_control_pkg::START_CONTROL_ADDR:
          rdata_nxt = {30'h0, enable_r, state_r == CONV_BUSY};
        default: begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = converter_input_control_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // one start per idle period; a trigger while busy is dropped
  always_comb begin
    state_nxt  = state_r;
    start_nxt  = 1'b0;
    result_nxt = result_r;
    unique case (state_r)
      CONV_IDLE: begin
        if (sw_start || (enable_r && hw_trigger)) begin
          state_nxt = CONV_BUSY;
          start_nxt = 1'b1;
        end
      end
      CONV_BUSY: begin
        if (done_edge) begin
          state_nxt  = CONV_IDLE;
          result_nxt = result_sync;
        end
      end
      default: state_nxt = CONV_IDLE;
    endcase
  end

  // channel is only honoured while connected; software keeps it steady otherwise
  always_comb begin
    pos_nxt  = converter_input_control_pkg::SWITCH_OFF;
    neg_nxt  = converter_input_control_pkg::SWITCH_OFF;
    half_nxt = 1'b0;
    if (control_r[converter_input_control_pkg::CONNECT_BIT]) begin
      if (control_r[converter_input_control_pkg::PAIR_MODE_BIT]) begin
        if (!control_r[converter_input_control_pkg::CHAN_HI]) begin
          pos_nxt[{control_r[1:0], 1'b0}] = 1'b1;
          neg_nxt[{control_r[1:0], 1'b1}] = 1'b1;
        end
      end else begin
        pos_nxt[control_r[2:0]] = 1'b1;
        half_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      control_r <= converter_input_control_pkg::REG_RESET;
      result_r  <= converter_input_control_pkg::REG_RESET;
      enable_r  <= 1'b0;
      state_r   <= CONV_IDLE;
      start_r   <= 1'b0;
      awaddr_r  <= 12'h000;
      aw_held_r <= 1'b0;
      wdata_r   <= 32'h00000000;
      wstrb0_r  <= 1'b0;
      w_held_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'h0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= 2'h0;
      pos_r     <= 8'h00;
      neg_r     <= 8'h00;
      half_r    <= 1'b0;
      done_d_r  <= 1'b0;
    end else begin
      control_r <= control_nxt;
      result_r  <= result_nxt;
      enable_r  <= enable_nxt;
      state_r   <= state_nxt;
      start_r   <= start_nxt;
      awaddr_r  <= awaddr_nxt;
      aw_held_r <= aw_held_nxt;
      wdata_r   <= wdata_nxt;
      wstrb0_r  <= wstrb0_nxt;
      w_held_r  <= w_held_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
      pos_r     <= pos_nxt;
      neg_r     <= neg_nxt;
      half_r    <= half_nxt;
      done_d_r  <= done_sync;
    end
  end

  assign o_conversion_start     = start_r;
  assign o_positive_switch      = pos_r;
  assign o_negative_switch      = neg_r;
  assign o_negative_half_supply = half_r;
  assign o_internal_reference   = control_r[converter_input_control_pkg::REF_SELECT_BIT];
  assign o_differential         = control_r[converter_input_control_pkg::PAIR_MODE_BIT];

  sequence s_idle_trigger;
    state_r == CONV_IDLE && enable_r && hw_trigger;
  endsequence
  sequence s_started;
    o_conversion_start && state_r == CONV_BUSY;
  endsequence

  a_result_reset: assert property (@(posedge i_clock) $rose(i_rst_b) |-> result_r == 8'h00)
    else $error("result register not zero after reset");
  a_control_write: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    wr_ok && awaddr_r == converter_input_control_pkg::INPUT_CONTROL_ADDR
    |=> control_r == $past(wdata_r[7:0]))
    else $error("control write not stored");
  a_inputs_isolated: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !control_r[converter_input_control_pkg::CONNECT_BIT] |=> pos_r == 8'h00 && neg_r == 8'h00)
    else $error("inputs not isolated");
  a_single_route: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    control_r[7] && !control_r[3] |=> pos_r == (8'h01 << $past(control_r[2:0])) && half_r)
    else $error("single-ended routing wrong");
  a_reference_follow: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    wr_ok && awaddr_r == converter_input_control_pkg::INPUT_CONTROL_ADDR
    |=> o_internal_reference == $past(wdata_r[converter_input_control_pkg::REF_SELECT_BIT]))
    else $error("reference select mismatch");
  a_timer_start: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    s_idle_trigger |=> s_started)
    else $error("timer overflow did not start conversion");
  a_busy_no_restart: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    state_r == CONV_BUSY && !done_edge |=> !o_conversion_start)
    else $error("second start while busy");
  a_done_clears: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    state_r == CONV_BUSY && done_edge |=> state_r == CONV_IDLE && result_r == $past(result_sync))
    else $error("busy not cleared on completion");
endmodule

// [rtl/converter_input_control_pkg.sv]
// constants for the converter input control block
package converter_input_control_pkg;
  localparam logic [7:0]  RESULT_HIGH_IDX   = 8'hDD;
  localparam logic [7:0]  INPUT_CONTROL_IDX = 8'hDA;
  localparam logic [7:0]  START_CONTROL_IDX = 8'hD8;
  localparam logic [11:0] RESULT_HIGH_ADDR   = {2'b00, RESULT_HIGH_IDX, 2'b00};
  localparam logic [11:0] INPUT_CONTROL_ADDR = {2'b00, INPUT_CONTROL_IDX, 2'b00};
  localparam logic [11:0] START_CONTROL_ADDR = {2'b00, START_CONTROL_IDX, 2'b00};
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam int          CONNECT_BIT    = 7;
  localparam int          REF_SELECT_BIT = 6;
  localparam int          TRIG_HI        = 5;
  localparam int          TRIG_LO        = 4;
  localparam int          PAIR_MODE_BIT  = 3;
  localparam int          CHAN_HI        = 2;
  localparam int          START_BIT      = 0;
  localparam int          ENABLE_BIT     = 1;
  localparam logic [1:0]  TRIG_SOFTWARE  = 2'h0;
  localparam logic [1:0]  TRIG_TIMER0    = 2'h1;
  localparam logic [1:0]  TRIG_TIMER1    = 2'h2;
  localparam logic [1:0]  TRIG_TIMER2    = 2'h3;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic [7:0]  SWITCH_OFF     = 8'h00;
endpackage

// [rtl/pin_sync.sv]
// two-flop synchroniser for outside levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_b,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end
  assign o_sync = sync_r;
endmodule

// [test/conv_core_model.sv]
// behavioural model of the analog converter core
`timescale 1ns/1ps
module conv_core_model #(
  parameter int LAT = 20
) (
  input  wire logic       i_clock,
  input  wire logic       i_rst_b,
  input  wire logic       i_start,
  output logic            o_done,
  output logic [7:0]      o_result
);
  int         cnt;
  logic [7:0] val;
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= 0;
      o_done <= 1'b0;
      o_result <= 8'h00;
      val <= 8'h3C;
    end else if (i_start) begin
      cnt <= LAT;
      o_done <= 1'b0;
      // result is not valid while converting, so show a changed value
      o_result <= ~o_result;
    end else if (cnt == 1) begin
      cnt <= 0;
      o_done <= 1'b1;
      o_result <= val;
      val <= val + 8'h11;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// [test/tb.sv]
// self-checking bench for the converter input control block
`timescale 1ns/1ps
module tb;
  logic i_clock = 1'b0, i_rst_b = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0;
  logic [2:0] tmr = '0;
  wire awready, wready, bvalid, arready, rvalid, start, done, half, ref_sel, differential;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] res, pos, neg;
  int fail_count = 0, samples_checked = 0, starts = 0, cyc = 0;
  logic [31:0] rd;
  logic [1:0] rr;
  logic [1:0] wb;
  always #20 i_clock = ~i_clock;
  converter_input_control uut (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .i_timer_overflow(tmr), .i_conversion_done(done), .i_result_high(res),
    .o_conversion_start(start), .o_positive_switch(pos), .o_negative_switch(neg),
    .o_negative_half_supply(half), .o_internal_reference(ref_sel),
    .o_differential(differential));
  conv_core_model core (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_start(start),
    .o_done(done), .o_result(res));
  always @(posedge i_clock) begin
    starts <= starts + (start === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic ta, tw, tb_;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(negedge i_clock);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb_ = bvalid;
      wb = bresp;
      @(posedge i_clock);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
    end while (!tb_);
    bready <= 0;
    // let an edge pass so a following call does not re-raise bready in the same step
    @(posedge i_clock);
  endtask
  task automatic rdr(input logic [11:0] a);
    logic ta, tr;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(negedge i_clock);
      ta = arvalid && arready;
      tr = rvalid;
      rd = rdata;
      rr = rresp;
      @(posedge i_clock);
      if (ta) arvalid <= 0;
    end while (!tr);
    rready <= 0;
    @(posedge i_clock);
  endtask
  task automatic outs(input logic [7:0] p, n, input logic h, r, d);
    repeat (2) @(posedge i_clock);
    // look mid-cycle, where the registered outputs have settled
    @(negedge i_clock);
    chk("pos", {24'h0, p}, {24'h0, pos});
    chk("neg", {24'h0, n}, {24'h0, neg});
    chk("ctl", {29'h0, h, r, d}, {29'h0, half, ref_sel, differential});
    @(posedge i_clock);
  endtask
  task automatic t_reset();
    rdr(converter_input_control_pkg::RESULT_HIGH_ADDR);
    chk("result_high", 32'h0, rd);
    chk("read_resp", {30'h0, converter_input_control_pkg::RESP_OKAY}, {30'h0, rr});
    rdr(converter_input_control_pkg::INPUT_CONTROL_ADDR);
    chk("input_control", 32'h0, rd);
    rdr(12'h000);
    chk("unmapped", {30'h0, converter_input_control_pkg::RESP_SLVERR}, {30'h0, rr});
    wr(12'h000, 8'h00);
    chk("unmapped_wr", {30'h0, converter_input_control_pkg::RESP_SLVERR}, {30'h0, wb});
    $display("test reset done");
  endtask
  task automatic t_route();
    int c;
    for (c = 0; c < 8; c++) begin
      wr(converter_input_control_pkg::INPUT_CONTROL_ADDR, 8'(c));
      outs(8'h00, 8'h00, 0, 0, 0);
      wr(converter_input_control_pkg::INPUT_CONTROL_ADDR, 8'h80 | 8'(c));
      outs(8'h01 << c, 8'h00, 1, 0, 0);
      rdr(converter_input_control_pkg::INPUT_CONTROL_ADDR);
      chk("ctl_read", 32'h80 | c, rd);
      // disconnect before the next channel change
      wr(converter_input_control_pkg::INPUT_CONTROL_ADDR, 8'(c));
    end
    for (c = 0; c < 8; c++) begin
      wr(converter_input_control_pkg::INPUT_CONTROL_ADDR, 8'h48 | 8'(c));
      wr(converter_input_control_pkg::INPUT_CONTROL_ADDR, 8'hC8 | 8'(c));
      // reserved differential codes leave every switch open
      if (c < 4) outs(8'h01 << (2 * c), 8'h02 << (2 * c), 0, 1, 1);
      else outs(8'h00, 8'h00, 0, 1, 1);
      wr(converter_input_control_pkg::INPUT_CONTROL_ADDR, 8'h48 | 8'(c));
    end
    wr(converter_input_control_pkg::INPUT_CONTROL_ADDR, 8'h00);
    $display("test routing done");
  endtask
  task automatic t_soft();
    int s;
    s = starts;
    wr(converter_input_control_pkg::START_CONTROL_ADDR, 8'h03);
    chk("start_wr_resp", {30'h0, converter_input_control_pkg::RESP_OKAY}, {30'h0, wb});
    rdr(converter_input_control_pkg::START_CONTROL_ADDR);
    chk("busy", 32'h3, rd);
    chk("starts", s + 1, starts);
    repeat (30) @(posedge i_clock);
    rdr(converter_input_control_pkg::START_CONTROL_ADDR);
    chk("idle", 32'h2, rd);
    wr(converter_input_control_pkg::RESULT_HIGH_ADDR, 8'hFF);
    chk("result_wr_resp", {30'h0, converter_input_control_pkg::RESP_OKAY}, {30'h0, wb});
    rdr(converter_input_control_pkg::RESULT_HIGH_ADDR);
    chk("result", {24'h0, res}, rd);
    $display("test software start done");
  endtask
  task automatic t_timer();
    int t, s;
    for (t = 1; t < 4; t++) begin
      wr(converter_input_control_pkg::INPUT_CONTROL_ADDR, 8'(t << 4));
      s = starts;
      tmr <= 3'b001 << (t % 3);
      repeat (4) @(posedge i_clock);
      tmr <= 3'b000;
      repeat (8) @(posedge i_clock);
      chk("other_timer", s, starts);
      tmr <= 3'b001 << (t - 1);
      repeat (4) @(posedge i_clock);
      tmr <= 3'b000;
      repeat (4) @(posedge i_clock);
      tmr <= 3'b001 << (t - 1);
      repeat (4) @(posedge i_clock);
      tmr <= 3'b000;
      repeat (8) @(posedge i_clock);
      // second overflow lands while busy and must be dropped
      chk("timer_start", s + 1, starts);
      repeat (30) @(posedge i_clock);
    end
    $display("test timer triggers done");
  endtask
  task automatic t_reset_again();
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_b <= 1'b1;
    @(posedge i_clock);
    rdr(converter_input_control_pkg::RESULT_HIGH_ADDR);
    chk("result_high_rst", 32'h0, rd);
    rdr(converter_input_control_pkg::INPUT_CONTROL_ADDR);
    chk("input_control_rst", 32'h0, rd);
    rdr(converter_input_control_pkg::START_CONTROL_ADDR);
    chk("start_control_rst", 32'h0, rd);
    $display("test mid-run reset done");
  endtask
  initial begin
    repeat (4) @(posedge i_clock);
    i_rst_b <= 1'b1;
    @(posedge i_clock);
    t_reset();
    t_route();
    t_soft();
    t_timer();
    t_reset_again();
    report_and_stop();
  end
endmodule
